// ==== hdl/nbc_map.vh ====
// constants for the nand bus host: op kinds, command codes, pin timing
`ifndef NBC_MAP_VH
`define NBC_MAP_VH

// ----------------------------------------------------------------------
// op kinds carried in bits [31:29] of a queued operation
// ----------------------------------------------------------------------
`define NBC_OP_CMD 3'h0
`define NBC_OP_ADDR5 3'h1
`define NBC_OP_ADDR1 3'h2
`define NBC_OP_WDATA 3'h3
`define NBC_OP_RDATA 3'h4
`define NBC_OP_WAITRDY 3'h5
`define NBC_OP_GUARD 3'h6

// ----------------------------------------------------------------------
// queued operation layout
// ----------------------------------------------------------------------
`define NBC_OPW 32
`define NBC_KIND_MSB 31
`define NBC_KIND_LSB 29
`define NBC_ARG_MSB 28
`define NBC_ADDR_CYCLES 3'h5

// ----------------------------------------------------------------------
// command codes sent on the low byte lines
// ----------------------------------------------------------------------
`define NBC_CMD_READ_SETUP 8'h00
`define NBC_CMD_READ_GO 8'h30
`define NBC_CMD_READ_COPYBACK 8'h35
`define NBC_CMD_CACHE_READ 8'h31
`define NBC_CMD_CACHE_EXIT 8'h34
`define NBC_CMD_PROG_SETUP 8'h80
`define NBC_CMD_PROG_GO 8'h10
`define NBC_CMD_CACHE_PROG 8'h15
`define NBC_CMD_COPYBACK_COL 8'h85
`define NBC_CMD_ERASE_SETUP 8'h60
`define NBC_CMD_ERASE_GO 8'hD0
`define NBC_CMD_RAND_OUT 8'h05
`define NBC_CMD_RAND_OUT_GO 8'hE0
`define NBC_CMD_READ_ID 8'h90
`define NBC_CMD_STATUS 8'h70
`define NBC_CMD_XSTATUS_LO 8'h72
`define NBC_CMD_XSTATUS_HI 8'h75
`define NBC_CMD_RESET 8'hFF

// ----------------------------------------------------------------------
// timing: clock rate and least times, in nanoseconds
// ----------------------------------------------------------------------
`define NBC_CLK_MHZ 10
`define NBC_T_STROBE_LOW_NS 100
`define NBC_T_STROBE_HIGH_NS 100
`define NBC_T_BUSY_ONSET_NS 200
`define NBC_RESET_GUARD 1'b0

`endif

// ==== hdl/nbc_fifo.v ====
// operation queue with registered read data and valid/ready on both sides
`timescale 1ns/1ps

module nbc_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 8
) (
   // clock and reset
   input wire clk_sys_i,
   input wire reset_n_i,
   // filling side
   input wire in_valid_i,
   input wire [WIDTH-1:0] in_data_i,
   output wire in_ready_o,
   // draining side
   output wire out_valid_o,
   output wire [WIDTH-1:0] out_data_o,
   input wire out_ready_i
);

   localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam [AW:0] DEPTH_C = DEPTH;
   localparam [AW:0] ONE_C = 1;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg [AW:0] count_next;
   reg not_full_reg;
   reg out_valid_reg;
   reg [WIDTH-1:0] out_data_reg;

   wire push = in_valid_i & not_full_reg;
   // refill the output register whenever it is empty or being taken
   wire load = (count_reg != {(AW+1){1'b0}}) & (~out_valid_reg | out_ready_i);

   assign in_ready_o = not_full_reg;
   assign out_valid_o = out_valid_reg;
   assign out_data_o = out_data_reg;

   // occupancy of the memory, not counting the output register
   always @* begin
      count_next = count_reg;
      if (push & ~load) begin
         count_next = count_reg + ONE_C;
      end else if (load & ~push) begin
         count_next = count_reg - ONE_C;
      end
   end

   // storage has no reset; only pointers and flags need one
   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_i;
      end
   end

   // pointers, full flag and output register
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         not_full_reg <= 1'b1;
         out_valid_reg <= 1'b0;
         out_data_reg <= {WIDTH{1'b0}};
      end else begin
         count_reg <= count_next;
         not_full_reg <= (count_next != DEPTH_C);
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH_C[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (load) begin
            out_data_reg <= mem[rd_ptr_reg];
            out_valid_reg <= 1'b1;
            rd_ptr_reg <= (rd_ptr_reg == DEPTH_C[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end else if (out_ready_i) begin
            out_valid_reg <= 1'b0;
         end
      end
   end

endmodule // nbc_fifo

// ==== hdl/nbc_host.v ====
// host controller that drives a nand flash over its strobe pins
//
// Behaviour
// R1: x8 address: five byte cycles, A0..A28
// R2: x16 address: five cycles, upper lines low
// R3: use documented command byte pairs and singles
// R4: copy-back 00h/35h then 85h/10h
// R5: strobe pulses far longer than glitch limit
// R6: command: CE low, CLE high, ALE low
// R7: write guard high for program and erase
// R8: command codes only on low byte lines
// R9: always send five address cycles; ADDR1 ops send one
// R10: address: CE low, ALE high, CLE low
// R11: address bytes only on low lines
// R12: data in: latches low, guard high
// R13: read: toggle read strobe, WE high
// R14: read returns array, status or id
// R15: guard low blocks program and erase
// R16: device samples guard continuously
// R17: chip select high means standby
// R18: optional select don't-care during latency
// R19: each read strobe fall gives next data
// R20: status mode holds after 70h
// R21: busy device takes status/reset only
// R22: wait ready before other commands
`timescale 1ns/1ps
`include "nbc_map.vh"

module nbc_host #(
   parameter BUS16 = 0,
   parameter FIFO_DEPTH = 8
) (
   // clock and reset
   input wire clk_sys_i,
   input wire reset_n_i,
   // user operation port
   input wire op_valid_i,
   input wire [2:0] op_kind_i,
   input wire [28:0] op_arg_i,
   output wire op_ready_o,
   // user results
   output reg [15:0] rd_data_o,
   output reg rd_valid_o,
   output reg refused_o,
   output reg busy_o,
   // flash pins
   output reg ce_n_o,
   output reg cle_o,
   output reg ale_o,
   output reg we_n_o,
   output reg read_strobe_n_o,
   output reg wp_n_o,
   output reg [15:0] io_o,
   output reg io_oe_o,
   input wire [15:0] io_i,
   input wire ready_busy_n_i
);

   // ----------------------------------------------------------------------
   // timing counts, least times rounded up to whole cycles
   // ----------------------------------------------------------------------
   localparam integer T_LOW_RAW = (`NBC_T_STROBE_LOW_NS * `NBC_CLK_MHZ + 999) / 1000;
   localparam integer T_HIGH_RAW = (`NBC_T_STROBE_HIGH_NS * `NBC_CLK_MHZ + 999) / 1000;
   localparam integer T_BUSY_RAW = (`NBC_T_BUSY_ONSET_NS * `NBC_CLK_MHZ + 999) / 1000;
   localparam [3:0] T_LOW_CYC = (T_LOW_RAW < 1) ? 4'h1 : T_LOW_RAW[3:0];
   localparam [3:0] T_HIGH_CYC = (T_HIGH_RAW < 1) ? 4'h1 : T_HIGH_RAW[3:0];
   localparam [3:0] T_BUSY_CYC = (T_BUSY_RAW < 1) ? 4'h1 : T_BUSY_RAW[3:0];

   // ----------------------------------------------------------------------
   // states
   // ----------------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_CHECK = 3'h1;
   localparam [2:0] ST_WAIT = 3'h2;
   localparam [2:0] ST_LOW = 3'h3;
   localparam [2:0] ST_HIGH = 3'h4;

   reg [2:0] state_reg;
   reg [3:0] tmr_reg;
   reg [2:0] cyc_reg;
   reg [`NBC_OPW-1:0] op_reg;
   reg rb_reg;

   wire f_valid;
   wire [`NBC_OPW-1:0] f_data;
   wire f_ready = (state_reg == ST_IDLE);
   wire [2:0] kind = op_reg[`NBC_KIND_MSB:`NBC_KIND_LSB];
   wire [28:0] arg = op_reg[`NBC_ARG_MSB:0];

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------

   // one address byte per cycle for the chosen bus width
   function [7:0] addr_byte;
      input [28:0] a;
      input [2:0] cyc;
      input wide;
      begin
         addr_byte = 8'h00;
         if (!wide) begin
            case (cyc)
               3'h0: addr_byte = a[7:0]; // R1
               3'h1: addr_byte = {4'h0, a[11:8]}; // R1
               3'h2: addr_byte = a[19:12]; // R1
               3'h3: addr_byte = a[27:20]; // R1
               3'h4: addr_byte = {7'h00, a[28]}; // R1
               default: addr_byte = 8'h00;
            endcase
         end else begin
            case (cyc)
               3'h0: addr_byte = a[7:0]; // R2
               3'h1: addr_byte = {5'h00, a[10:8]}; // R2
               3'h2: addr_byte = a[18:11]; // R2
               3'h3: addr_byte = a[26:19]; // R2
               3'h4: addr_byte = {7'h00, a[27]}; // R2
               default: addr_byte = 8'h00;
            endcase
         end
      end
   endfunction

   // commands that start or feed a modify operation
   function is_modify;
      input [7:0] c;
      begin
         is_modify = (c == `NBC_CMD_PROG_SETUP) || (c == `NBC_CMD_PROG_GO) || // R3
            (c == `NBC_CMD_CACHE_PROG) || (c == `NBC_CMD_COPYBACK_COL) || // R4
            (c == `NBC_CMD_ERASE_SETUP) || (c == `NBC_CMD_ERASE_GO);
      end
   endfunction

   // commands a busy device still takes
   function busy_ok;
      input [7:0] c;
      begin
         busy_ok = (c == `NBC_CMD_STATUS) || (c == `NBC_CMD_RESET) ||
            ((c >= `NBC_CMD_XSTATUS_LO) && (c <= `NBC_CMD_XSTATUS_HI)); // R21
      end
   endfunction

   // word put on the data lines for the current bus cycle
   function [15:0] out_word;
      input [2:0] k;
      input [28:0] a;
      input [2:0] cyc;
      begin
         case (k)
            `NBC_OP_ADDR5: out_word = {8'h00, addr_byte(a, cyc, BUS16 != 0)}; // R11
            `NBC_OP_WDATA: out_word = (BUS16 != 0) ? a[15:0] : {8'h00, a[7:0]};
            default: out_word = {8'h00, a[7:0]}; // R8
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // operation queue; the engine only drains it while idle
   // ----------------------------------------------------------------------
   nbc_fifo #(
      .WIDTH(`NBC_OPW),
      .DEPTH(FIFO_DEPTH)
   ) u_queue (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .in_valid_i(op_valid_i),
      .in_data_i({op_kind_i, op_arg_i}),
      .in_ready_o(op_ready_o),
      .out_valid_o(f_valid),
      .out_data_o(f_data),
      .out_ready_i(f_ready)
   );

   // ----------------------------------------------------------------------
   // bus engine
   // ----------------------------------------------------------------------

   // ready/busy is taken as synchronous; one register stage suffices
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rb_reg <= 1'b0;
      end else begin
         rb_reg <= ready_busy_n_i;
      end
   end

   // main sequencer: one strobe low phase, one high phase per bus cycle
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ST_IDLE;
         tmr_reg <= 4'h0;
         cyc_reg <= 3'h0;
         op_reg <= {`NBC_OPW{1'b0}};
         rd_data_o <= 16'h0000;
         rd_valid_o <= 1'b0;
         refused_o <= 1'b0;
         busy_o <= 1'b0;
         ce_n_o <= 1'b1;
         cle_o <= 1'b0;
         ale_o <= 1'b0;
         we_n_o <= 1'b1;
         read_strobe_n_o <= 1'b1;
         wp_n_o <= `NBC_RESET_GUARD; // protected until software opens it
         io_o <= 16'h0000;
         io_oe_o <= 1'b0;
      end else begin
         rd_valid_o <= 1'b0;
         refused_o <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (f_valid) begin
                  op_reg <= f_data;
                  ce_n_o <= 1'b0;
                  busy_o <= 1'b1;
                  cyc_reg <= 3'h0;
                  state_reg <= ST_CHECK;
               end else begin
                  ce_n_o <= 1'b1; // R17
                  busy_o <= 1'b0;
               end
            end
            ST_CHECK: begin
               tmr_reg <= T_BUSY_CYC;
               if (kind == `NBC_OP_GUARD) begin
                  // guard only moves between bus cycles, never under a strobe
                  wp_n_o <= arg[0]; // R16
                  state_reg <= ST_IDLE;
               end else if (kind == `NBC_OP_WAITRDY) begin
                  state_reg <= ST_WAIT;
               end else if (!wp_n_o && ((kind == `NBC_OP_WDATA) ||
                     ((kind == `NBC_OP_CMD) && is_modify(arg[7:0])))) begin
                  refused_o <= 1'b1; // R7 R15
                  state_reg <= ST_IDLE;
               end else if ((kind == `NBC_OP_CMD) && !busy_ok(arg[7:0]) && !rb_reg) begin
                  state_reg <= ST_WAIT; // R22
               end else begin
                  tmr_reg <= T_LOW_CYC - 4'h1;
                  io_o <= out_word(kind, arg, 3'h0);
                  state_reg <= ST_LOW;
                  if (kind == `NBC_OP_RDATA) begin
                     read_strobe_n_o <= 1'b0; // R13 R19
                  end else begin
                     we_n_o <= 1'b0;
                     io_oe_o <= 1'b1;
                     cle_o <= (kind == `NBC_OP_CMD); // R6
                     ale_o <= (kind == `NBC_OP_ADDR5) || (kind == `NBC_OP_ADDR1); // R10
                  end
               end
            end
            ST_WAIT: begin
               // give the device time to pull busy before trusting ready
               if (tmr_reg != 4'h0) begin
                  tmr_reg <= tmr_reg - 4'h1;
               end else if (rb_reg) begin
                  state_reg <= (kind == `NBC_OP_WAITRDY) ? ST_IDLE : ST_CHECK; // R22
                  if (kind != `NBC_OP_WAITRDY) begin
                     op_reg[`NBC_KIND_MSB:`NBC_KIND_LSB] <= kind;
                  end
               end
            end
            ST_LOW: begin
               // strobe held low for whole cycles, far past any glitch filter
               if (tmr_reg != 4'h0) begin
                  tmr_reg <= tmr_reg - 4'h1; // R5
               end else begin
                  tmr_reg <= T_HIGH_CYC - 4'h1;
                  state_reg <= ST_HIGH;
                  if (kind == `NBC_OP_RDATA) begin
                     // sampled just before the rise; data must be valid by then
                     rd_data_o <= (BUS16 != 0) ? io_i : {8'h00, io_i[7:0]}; // R14
                     rd_valid_o <= 1'b1;
                     read_strobe_n_o <= 1'b1;
                  end else begin
                     we_n_o <= 1'b1; // R12
                  end
               end
            end
            ST_HIGH: begin
               // latches and data held through the high phase for hold time
               if (tmr_reg != 4'h0) begin
                  tmr_reg <= tmr_reg - 4'h1;
               end else if ((kind == `NBC_OP_ADDR5) && (cyc_reg != `NBC_ADDR_CYCLES - 3'h1)) begin
                  cyc_reg <= cyc_reg + 3'h1; // R9
                  io_o <= out_word(kind, arg, cyc_reg + 3'h1);
                  we_n_o <= 1'b0;
                  tmr_reg <= T_LOW_CYC - 4'h1;
                  state_reg <= ST_LOW;
               end else begin
                  cle_o <= 1'b0;
                  ale_o <= 1'b0;
                  io_oe_o <= 1'b0;
                  io_o <= 16'h0000;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // nbc_host

// ==== sim/nbc_flash_model.sv ====
// behavioural flash device for the nand bus host bench
`timescale 1ns/1ps

module nbc_flash_model #(
   parameter BUSY_NS = 500,
   parameter [7:0] ID_BYTE = 8'h3C, // arbitrary value
   parameter [7:0] STAT_BYTE = 8'hE0
) (
   // strobes and latch enables from the host
   input wire ce_n_i,
   input wire cle_i,
   input wire ale_i,
   input wire we_n_i,
   input wire read_strobe_n_i,
   input wire wp_n_i,
   // data lines and bench control
   input wire [15:0] io_i,
   input wire hold_busy_i,
   output logic [15:0] io_o,
   output wire ready_busy_n_o
);
   // ------------------------------------------------------------
   // bus capture log, read by the bench
   // ------------------------------------------------------------
   logic [17:0] log_q [$];
   logic [7:0] col = 8'h00;
   logic [7:0] mode = 8'h00;
   logic busy = 1'b0;
   logic [15:0] last = 16'h0000;
   int acnt = 0;

   // open drain line; busy timer ignores chip select
   assign ready_busy_n_o = !(busy || hold_busy_i);

   // latch on write strobe rise; guard looked at as a level, not a latched bit
   always @(posedge we_n_i) begin
      if (!ce_n_i && read_strobe_n_i && cle_i && !ale_i) begin
         log_q.push_back({2'h1, io_i});
         acnt = 0;
         if (!busy || io_i[7:0] == 8'h70 || io_i[7:0] == 8'hFF) mode = io_i[7:0];
         if (io_i[7:0] inside {8'h30, 8'h31, 8'h35} ||
             (wp_n_i && io_i[7:0] inside {8'h10, 8'h15, 8'hD0})) begin
            busy = 1'b1;
            busy <= #(BUSY_NS) 1'b0;
         end
      end else if (!ce_n_i && read_strobe_n_i && ale_i && !cle_i) begin
         log_q.push_back({2'h2, io_i});
         if (acnt == 0) col = io_i[7:0];
         acnt++;
      end else if (!ce_n_i && read_strobe_n_i && !ale_i && !cle_i && wp_n_i) begin
         log_q.push_back({2'h3, io_i});
      end
   end

   // each read strobe fall gives the next word of the selected source
   always @(negedge read_strobe_n_i) begin
      if (!ce_n_i && we_n_i) begin
         case (mode)
            8'h70: last = {8'h00, STAT_BYTE};
            8'h90: last = {8'h00, ID_BYTE};
            default: begin
               last = {~col, col ^ 8'h5A};
               col++;
            end
         endcase
      end
   end

   // released lines show the inverse so a stale value never matches
   always @* io_o = (!ce_n_i && !read_strobe_n_i) ? last : ~last;
endmodule // nbc_flash_model

// ==== sim/nbc_host_chk.sv ====
// pin protocol checker for the nand bus host
`timescale 1ns/1ps

module nbc_host_chk #(
   parameter BUS16 = 0
) (
   // clock and reset
   input wire clk_sys_i,
   input wire reset_n_i,
   // watched outputs
   input wire [15:0] rd_data_o,
   input wire rd_valid_o,
   input wire ce_n_o,
   input wire cle_o,
   input wire ale_o,
   input wire we_n_o,
   input wire read_strobe_n_o,
   input wire wp_n_o,
   input wire [15:0] io_o,
   input wire io_oe_o
);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   AST_CMD_LATCH: assert property ($rose(we_n_o) && cle_o |->
      !ale_o && !ce_n_o && read_strobe_n_o && io_oe_o) else $error("bad command latch");
   AST_ADDR_LATCH: assert property ($rose(we_n_o) && ale_o |->
      !cle_o && !ce_n_o && read_strobe_n_o && io_oe_o) else $error("bad address latch");
   AST_LOW_LINES: assert property ((cle_o || ale_o) && !we_n_o |->
      io_o[15:8] == 8'h00) else $error("upper lines not low");
   AST_READ_PINS: assert property (!read_strobe_n_o |->
      we_n_o && !cle_o && !ale_o && !ce_n_o && !io_oe_o) else $error("bad read pins");
   AST_GUARD_CMD: assert property (!we_n_o && cle_o && !wp_n_o |->
      !(io_o[7:0] inside {8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0}))
      else $error("modify command while guarded");
   AST_DATA_GUARD: assert property (!we_n_o && !cle_o && !ale_o |-> wp_n_o && !ce_n_o)
      else $error("data written while guarded");
   AST_WE_PULSE: assert property ($fell(we_n_o) |=> we_n_o)
      else $error("write strobe width");
   AST_RE_PULSE: assert property ($fell(read_strobe_n_o) |=>
      read_strobe_n_o && rd_valid_o ##1 !rd_valid_o) else $error("read strobe or valid pulse");
   AST_NARROW_READ: assert property (rd_valid_o && BUS16 == 0 |-> rd_data_o[15:8] == 8'h00)
      else $error("narrow read upper byte");
   AST_STANDBY: assert property (ce_n_o |->
      we_n_o && read_strobe_n_o && !io_oe_o && !cle_o && !ale_o) else $error("active while deselected");
endmodule // nbc_host_chk

bind nbc_host nbc_host_chk #(.BUS16(BUS16)) i_chk (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .rd_data_o(rd_data_o),
   .rd_valid_o(rd_valid_o), .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o),
   .read_strobe_n_o(read_strobe_n_o), .wp_n_o(wp_n_o), .io_o(io_o), .io_oe_o(io_oe_o));

// ==== sim/testbench.sv ====
// self-checking bench: x8 and x16 hosts fed the same ops, each with a flash model
`timescale 1ns/1ps

module testbench;
   typedef struct {logic [2:0] k; logic [28:0] a; int n; logic [17:0] e [5];} nbc_row_t;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic op_valid = 1'b0;
   logic hold = 1'b0;
   logic [2:0] op_kind = 3'h0;
   logic [28:0] op_arg = 29'h0;
   logic [15:0] rd_last = 16'h0;
   logic [15:0] rd_wide = 16'h0;
   wire [15:0] rd_data [2], io_o [2], flq [2], bus [2];
   wire ce_n [2], cle [2], ale [2], we_n [2], re_n [2], wp_n [2], oe [2], rb [2];
   wire rdy [2], rdv [2], refd [2], busy [2];
   int err_count = 0;
   int total_checks = 0;
   int refused_cnt = 0;
   int base, n, i;
   nbc_row_t rows [$];
   logic [7:0] cmds [10] = '{8'h60, 8'hD0, 8'h05, 8'hE0, 8'h31, 8'h34, 8'h35, 8'h15, 8'h75, 8'hFF};
   logic [7:0] mods [6] = '{8'h80, 8'h10, 8'h15, 8'h85, 8'h60, 8'hD0};
   logic [17:0] wide_addr [5] = '{18'h20078, 18'h20006, 18'h2008A, 18'h20046, 18'h20000};

   // ------------------------------------------------------------
   // two hosts, one per bus width, each on its own flash model
   // ------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_side
      nbc_host #(.BUS16(g), .FIFO_DEPTH(8)) i_dut (
         .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .op_valid_i(op_valid),
         .op_kind_i(op_kind), .op_arg_i(op_arg), .op_ready_o(rdy[g]), .rd_data_o(rd_data[g]),
         .rd_valid_o(rdv[g]), .refused_o(refd[g]), .busy_o(busy[g]), .ce_n_o(ce_n[g]),
         .cle_o(cle[g]), .ale_o(ale[g]), .we_n_o(we_n[g]), .read_strobe_n_o(re_n[g]),
         .wp_n_o(wp_n[g]), .io_o(io_o[g]), .io_oe_o(oe[g]), .io_i(bus[g]),
         .ready_busy_n_i(rb[g]));
      nbc_flash_model i_flash (
         .ce_n_i(ce_n[g]), .cle_i(cle[g]), .ale_i(ale[g]), .we_n_i(we_n[g]),
         .read_strobe_n_i(re_n[g]), .wp_n_i(wp_n[g]), .io_i(bus[g]), .hold_busy_i(hold),
         .io_o(flq[g]), .ready_busy_n_o(rb[g]));
      // the host's enable decides who owns the shared lines
      assign bus[g] = oe[g] ? io_o[g] : flq[g];
   end

   // clock, read capture and refusal count
   always #50 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (rdv[0] === 1'b1) rd_last <= rd_data[0];
   always @(posedge clk_sys_i) if (rdv[1] === 1'b1) rd_wide <= rd_data[1];
   always @(posedge clk_sys_i) if (refd[0] === 1'b1) refused_cnt++;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      if (err_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // leaves valid up at the negedge after the taking edge
   task automatic send(input logic [2:0] k, input logic [28:0] a);
      int w;
      op_kind = k;
      op_arg = a;
      op_valid = 1'b1;
      w = 0;
      while (!(rdy[0] === 1'b1 && rdy[1] === 1'b1) && w < 5000) begin
         @(negedge clk_sys_i);
         w++;
      end
      @(negedge clk_sys_i);
   endtask

   task automatic drain;
      int w;
      op_valid = 1'b0;
      repeat (4) @(negedge clk_sys_i);
      w = 0;
      while ((busy[0] !== 1'b0 || busy[1] !== 1'b0) && w < 20000) begin
         @(negedge clk_sys_i);
         w++;
      end
   endtask

   task automatic add(input logic [2:0] k, input logic [28:0] a, input int n,
      input logic [17:0] e0 = 0, e1 = 0, e2 = 0, e3 = 0, e4 = 0);
      rows.push_back('{k, a, n, '{e0, e1, e2, e3, e4}});
   endtask

   // watchdog, reckoned well above the expected run
   initial begin
      #(5_000_000);
      err_count++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      add(3'h6, 29'h1, 0);
      add(3'h0, 29'h00, 1, 18'h10000);
      add(3'h1, 29'h12345678, 5, 18'h20078, 18'h20006, 18'h20045, 18'h20023, 18'h20001);
      add(3'h0, 29'h30, 1, 18'h10030);
      add(3'h5, 29'h0, 0);
      add(3'h4, 29'h0, 0, 18'h00022, 18'h08722);
      add(3'h4, 29'h0, 0, 18'h00023, 18'h08623);
      add(3'h0, 29'h80, 1, 18'h10080);
      add(3'h2, 29'h11, 1, 18'h20011);
      add(3'h3, 29'hA5C3, 1, 18'h300C3, 18'h3A5C3);
      add(3'h0, 29'h85, 1, 18'h10085);
      add(3'h0, 29'h10, 1, 18'h10010);
      add(3'h0, 29'h70, 1, 18'h10070);
      add(3'h4, 29'h0, 0, 18'h000E0, 18'h000E0);
      add(3'h4, 29'h0, 0, 18'h000E0, 18'h000E0);
      add(3'h0, 29'h90, 1, 18'h10090);
      add(3'h2, 29'h00, 1, 18'h20000);
      add(3'h4, 29'h0, 0, 18'h0003C, 18'h0003C);
      foreach (cmds[j]) add(3'h0, {21'h0, cmds[j]}, 1, {10'h100, cmds[j]});
      repeat (16) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      @(negedge clk_sys_i);
      check({ce_n[0], wp_n[0], oe[0], busy[0], rdy[0], we_n[0], re_n[0]}, 7'h47);
      // table rows: every op kind and every command code except 72h
      foreach (rows[r]) begin
         base = g_side[0].i_flash.log_q.size();
         send(rows[r].k, rows[r].a);
         drain();
         if (rows[r].k == 3'h4) check(rd_last, rows[r].e[0]);
         if (rows[r].k == 3'h4) check(rd_wide, rows[r].e[1]);
         if (rows[r].k == 3'h3) check(g_side[1].i_flash.log_q[base], rows[r].e[1]);
         for (i = 0; i < rows[r].n; i++)
            check(g_side[0].i_flash.log_q[base + i], rows[r].e[i]);
         check(g_side[0].i_flash.log_q.size(), base + rows[r].n);
      end
      // wide host: same address on the x16 map
      for (i = 0; i < 5; i++) check(g_side[1].i_flash.log_q[1 + i], wide_addr[i]);
      // guard closed: every modify code and data word is dropped
      send(3'h6, 29'h0);
      drain();
      base = g_side[0].i_flash.log_q.size();
      n = refused_cnt;
      foreach (mods[j]) send(3'h0, {21'h0, mods[j]});
      send(3'h3, 29'h5A);
      send(3'h0, 29'h70);
      drain();
      check(refused_cnt - n, 7);
      check(g_side[0].i_flash.log_q.size(), base + 1);
      check(wp_n[1], 1'b0);
      // queue fill behind a stalled ready wait, then drain
      hold = 1'b1;
      base = g_side[0].i_flash.log_q.size();
      send(3'h5, 29'h0);
      op_kind = 3'h0;
      op_arg = 29'h70;
      n = 0;
      while (rdy[0] === 1'b1 && rdy[1] === 1'b1 && n < 20) begin
         @(negedge clk_sys_i);
         n++;
      end
      check(n, 9);
      repeat (10) @(negedge clk_sys_i);
      check({rdy[0], rdy[1]}, 2'b00);
      check(g_side[0].i_flash.log_q.size(), base);
      hold = 1'b0;
      drain();
      check(g_side[0].i_flash.log_q.size(), base + 9);
      check({ce_n[0], busy[0], rdy[0]}, 3'b101);
      tally_and_finish();
   end
endmodule // testbench
